// >>> hdl/clm_clk_mon.sv
// transmit clock watchdog timed by the crystal clock
`timescale 1ns/1ps
`include "clm_map.svh"
module clm_clk_mon #(
	parameter int MISS_CYC = `CLM_MISS_CYC
) (
	input  wire logic clk,
	input  wire logic arst_n,
	input  wire logic enable,
	input  wire logic clk_edge,
	output logic      missing_ff
);
	logic [7:0] quiet_ff;

	// cycles since the last transition, restarted by each edge
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			quiet_ff <= 8'h00;
		end else if (!enable || clk_edge) begin
			quiet_ff <= 8'h00; // [R24]
		end else if (quiet_ff != 8'(MISS_CYC)) begin
			quiet_ff <= quiet_ff + 8'h01; // [R24]
		end
	end

	// flag clears when an edge is seen again or the monitor is disabled
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			missing_ff <= 1'b0;
		end else if (!enable || clk_edge) begin
			missing_ff <= 1'b0; // [R18]
		end else if (quiet_ff == 8'(MISS_CYC - 1)) begin
			missing_ff <= 1'b1; // [R17]
		end
	end

	miss_set_a: assert property (@(posedge clk) disable iff (!arst_n) // [R17]
		(enable && !clk_edge) [*8] |=> missing_ff)
		else $error("missing clock not flagged");
	miss_hold_a: assert property (@(posedge clk) disable iff (!arst_n) // [R18]
		(missing_ff && enable && !clk_edge) |=> missing_ff)
		else $error("missing clock dropped early");
endmodule : clm_clk_mon

// >>> hdl/clm_cmi_enc.sv
// CMI encoder giving both half-bit levels of each bit slot
`timescale 1ns/1ps
module clm_cmi_enc (
	input  wire logic clk,
	input  wire logic arst_n,
	input  wire logic bit_stb,
	input  wire logic bit_in,
	input  wire logic halt,
	output logic      half1_ff,
	output logic      half2_ff
);
	logic last_one_ff;

	// last-one polarity starts high so the first one goes out low
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			last_one_ff <= 1'b1; // [R23]
		end else if (bit_stb && bit_in && !halt) begin
			last_one_ff <= ~last_one_ff; // [R16]
		end
	end

	// halves hold for the whole slot; idle low while halted
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			half1_ff <= 1'b0;
			half2_ff <= 1'b0;
		end else if (halt) begin
			half1_ff <= 1'b0;
			half2_ff <= 1'b0;
		end else if (bit_stb) begin
			half1_ff <= bit_in ? ~last_one_ff : 1'b0; // [R16]
			half2_ff <= bit_in ? ~last_one_ff : 1'b1; // [R16]
		end
	end

	one_alt_a: assert property (@(posedge clk) disable iff (!arst_n) // [R16]
		(bit_stb && bit_in && !halt) |=> (half1_ff == half2_ff)
		&& (half1_ff != $past(last_one_ff)))
		else $error("cmi one level wrong");
endmodule : clm_cmi_enc

// >>> hdl/clm_line_coder.sv
// transmit line coder, clock monitor and receive status pins
//
// Added by the designer: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "clm_map.svh"
module clm_line_coder (
	input  wire logic        clk,
	input  wire logic        arst_n,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [11:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// strap pins
	input  wire logic        strap_select,
	input  wire logic        line_mode_pin,
	input  wire logic        parallel_sel_pin,
	input  wire logic        xtal_ref_pin,
	input  wire logic        rx_align_enable_pin,
	input  wire logic        remote_loop_select,
	input  wire logic        chip_addr_bit_one,
	input  wire logic        chip_addr_bit_zero,
	// transmit system side
	input  wire logic        tx_byte_clock,
	input  wire logic [7:0]  tx_byte_in,
	input  wire logic        tx_bit_clock_p,
	input  wire logic        tx_serial_data_p,
	// receive analog status
	input  wire logic        pll_locked,
	input  wire logic        signal_lost,
	// recovered receive stream, same clock
	input  wire logic        rx_byte_valid,
	input  wire logic [7:0]  rx_byte_data,
	input  wire logic        rx_bit_valid,
	input  wire logic        rx_bit_data,
	input  wire logic        rx_code_err,
	// line and status outputs
	output logic             coax_out_p,
	output logic             coax_out_n,
	output logic             fiber_out_p,
	output logic             fiber_out_n,
	output logic             rx_frame_pulse,
	output logic             rx_pll_lock,
	output logic             no_signal_alarm,
	output logic             rx_bit_clock_p,
	output logic             rx_bit_clock_n,
	output logic             rx_serial_data_p,
	output logic             rx_serial_data_n,
	output logic             rx_serial_oe,
	output logic [7:0]       rx_byte_out,
	output logic [1:0]       host_addr,
	output logic             tx_clock_missing
);
	localparam int NS = 21;

	logic [NS-1:0]          s1_ff;
	logic [NS-1:0]          s2_ff;
	logic                   byte_clk_d_ff;
	logic                   bit_clk_d_ff;
	logic [`CLM_CTRL_W-1:0] ctrl_ff;
	logic                   ap_wr_ff;
	logic                   ap_ctrl_ff;
	logic [`CLM_CTRL_W-1:0] ctrl_view;
	logic [7:0]             shift_ff;
	logic [3:0]             left_ff;
	logic                   bit_stb_ff;
	logic                   bit_val_ff;
	logic                   fib_ff;
	logic                   fibn_ff;
	logic                   half1;
	logic                   half2;
	logic                   missing;
	clm_pkg::clm_det_t      det_ff;
	clm_pkg::clm_det_t      nxt_det;
	logic                   hit;
	logic                   armed_ff;
	logic [3:0]             cnt_ff;
	logic                   fp_ff;
	logic                   fire;
	logic [3:0]             span_ff;
	logic                   err_seen_ff;
	logic [1:0]             cv_left_ff;
	logic                   frame_ff;
	logic                   lock_ff;
	logic                   alarm_ff;
	logic                   rbclk_ff;
	logic                   rbdat_ff;
	logic                   oe_ff;
	logic [7:0]             rbyte_ff;
	logic [1:0]             addr_ff;

	// two flops on every strap, analog status and transmit pin before any logic looks at it
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s1_ff <= '0;
			s2_ff <= '0;
		end else begin
			s1_ff <= {strap_select, line_mode_pin, parallel_sel_pin, xtal_ref_pin,
				rx_align_enable_pin, remote_loop_select, chip_addr_bit_one,
				chip_addr_bit_zero, pll_locked, signal_lost, tx_byte_clock,
				tx_bit_clock_p, tx_serial_data_p, tx_byte_in};
			s2_ff <= s1_ff;
		end
	end

	wire       sw_mode  = s2_ff[20]; // [R9]
	wire       lock_s   = s2_ff[12];
	wire       lost_s   = s2_ff[11];
	wire       bclk_s   = s2_ff[10];
	wire       sclk_s   = s2_ff[9];
	wire       sdat_s   = s2_ff[8];
	wire [7:0] byte_s   = s2_ff[7:0];

	// mode selection: straps and a fixed pulse position of 0 in hardware mode, control bits in software
	wire cmi_mode = sw_mode ? ctrl_ff[`CLM_C_LINE] : s2_ff[19]; // [R12]
	wire par_mode = sw_mode ? ctrl_ff[`CLM_C_PAR] : s2_ff[18];
	wire xref     = sw_mode ? ctrl_ff[`CLM_C_XREF] : s2_ff[17];
	wire align_en = sw_mode ? ctrl_ff[`CLM_C_ALIGN] : s2_ff[16]; // [R3]
	wire rloop    = sw_mode ? ctrl_ff[`CLM_C_RLOOP] : s2_ff[15];
	wire [3:0] fp_pos = sw_mode ? ctrl_ff[`CLM_C_POS +: 4] : 4'h0; // [R2]

	// monitor runs on crystal reference, never in remote loop
	wire mon_en = xref && !rloop && (!sw_mode || ctrl_ff[`CLM_C_MON]); // [R19]

	// previous synced clock levels for edge finding
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			byte_clk_d_ff <= 1'b0;
			bit_clk_d_ff  <= 1'b0;
		end else begin
			byte_clk_d_ff <= bclk_s;
			bit_clk_d_ff  <= sclk_s;
		end
	end

	wire byte_fall = byte_clk_d_ff && !bclk_s;
	wire bit_rise  = !bit_clk_d_ff && sclk_s;
	wire act_edge  = par_mode ? (byte_clk_d_ff ^ bclk_s) : (bit_clk_d_ff ^ sclk_s);

	// AHB address phase capture; zero wait, always OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	wire ap_take = hsel && hready && htrans[1];

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ap_wr_ff   <= 1'b0;
			ap_ctrl_ff <= 1'b0;
		end else if (hready) begin
			ap_wr_ff   <= ap_take && hwrite;
			ap_ctrl_ff <= haddr == `CLM_CTRL_OFS;
		end
	end

	// a write still in its data phase is forwarded to a following read
	assign ctrl_view = (ap_wr_ff && ap_ctrl_ff) ? hwdata[`CLM_CTRL_W-1:0] : ctrl_ff;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_ff <= `CLM_CTRL_RST;
		end else begin
			ctrl_ff <= ctrl_view; // [R20]
		end
	end

	// read data registered at the address phase; unmapped reads zero
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			hrdata <= 32'h0000_0000;
		end else if (ap_take && !hwrite) begin
			case (haddr)
				`CLM_CTRL_OFS: hrdata <= {21'h000000, ctrl_view};
				`CLM_STAT_OFS: hrdata <= {26'h0000000, addr_ff, sw_mode,
					alarm_ff, lock_ff, missing};
				default: hrdata <= 32'h0000_0000;
			endcase
		end
	end

	// serializer: byte clock times 8, one bit a cycle, MSB first
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			shift_ff   <= 8'h00;
			left_ff    <= 4'h0;
			bit_stb_ff <= 1'b0;
			bit_val_ff <= 1'b0;
		end else if (par_mode) begin
			bit_stb_ff <= byte_fall || (left_ff != 4'h0); // [R13]
			if (byte_fall) begin
				bit_val_ff <= byte_s[7]; // [R21]
				shift_ff   <= {byte_s[6:0], 1'b0};
				left_ff    <= 4'h7;
			end else if (left_ff != 4'h0) begin
				bit_val_ff <= shift_ff[7]; // [R21]
				shift_ff   <= {shift_ff[6:0], 1'b0};
				left_ff    <= left_ff - 4'h1;
			end
		end else begin
			left_ff    <= 4'h0;
			bit_stb_ff <= bit_rise; // [R14]
			if (bit_rise) begin
				bit_val_ff <= sdat_s; // [R14]
			end
		end
	end

	clm_clk_mon u_mon (
		.clk        (clk),
		.arst_n     (arst_n),
		.enable     (mon_en),
		.clk_edge   (act_edge),
		.missing_ff (missing)
	);

	clm_cmi_enc u_cmi (
		.clk      (clk),
		.arst_n   (arst_n),
		.bit_stb  (bit_stb_ff && cmi_mode),
		.bit_in   (bit_val_ff),
		.halt     (missing || !cmi_mode),
		.half1_ff (half1),
		.half2_ff (half2)
	);

	// NRZ pair from flops, both low while halted or while coax is chosen
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fib_ff  <= 1'b0;
			fibn_ff <= 1'b0;
		end else if (missing || cmi_mode) begin
			fib_ff  <= 1'b0; // [R17]
			fibn_ff <= 1'b0;
		end else if (bit_stb_ff) begin
			fib_ff  <= bit_val_ff; // [R15]
			fibn_ff <= !bit_val_ff;
		end
	end

	// coax pair carries the two half-bit levels of each slot
	assign coax_out_p       = half1; // [R15]
	assign coax_out_n       = half2;
	assign fiber_out_p      = fib_ff;
	assign fiber_out_n      = fibn_ff;
	assign tx_clock_missing = missing;

	// marker search over the aligned byte stream
	always_comb begin
		nxt_det = det_ff;
		hit     = 1'b0;
		case (det_ff)
			clm_pkg::CLM_D_IDLE: nxt_det = (rx_byte_data == `CLM_A1) ?
				clm_pkg::CLM_D_A1 : clm_pkg::CLM_D_IDLE;
			clm_pkg::CLM_D_A1: nxt_det = (rx_byte_data == `CLM_A1) ?
				clm_pkg::CLM_D_A1A1 : clm_pkg::CLM_D_IDLE;
			clm_pkg::CLM_D_A1A1: begin
				if (rx_byte_data == `CLM_A2) begin
					nxt_det = clm_pkg::CLM_D_A2;
				end else if (rx_byte_data != `CLM_A1) begin
					nxt_det = clm_pkg::CLM_D_IDLE;
				end
			end
			clm_pkg::CLM_D_A2: begin
				hit     = rx_byte_data == `CLM_A2; // [R1]
				nxt_det = (rx_byte_data == `CLM_A1) ?
					clm_pkg::CLM_D_A1 : clm_pkg::CLM_D_IDLE;
			end
			default: nxt_det = clm_pkg::CLM_D_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			det_ff <= clm_pkg::CLM_D_IDLE;
		end else if (rx_byte_valid) begin
			det_ff <= nxt_det;
		end
	end

	wire frame_act = par_mode && align_en;
	assign fire = rx_byte_valid && frame_act &&
		((hit && fp_pos == 4'h0) || (armed_ff && cnt_ff == fp_pos)); // [R2]

	// byte counter from the final A2 to the programmed position
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			armed_ff <= 1'b0;
			cnt_ff   <= 4'h0;
		end else if (rx_byte_valid) begin
			if (hit && fp_pos != 4'h0) begin
				armed_ff <= 1'b1;
				cnt_ff   <= 4'h1;
			end else if (fire) begin
				armed_ff <= 1'b0;
			end else if (armed_ff) begin
				cnt_ff <= cnt_ff + 4'h1;
			end
		end
	end

	// pulse holds from one byte strobe to the next
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fp_ff <= 1'b0;
		end else if (rx_byte_valid) begin
			fp_ff <= fire; // [R22]
		end
	end

	// violation spans of 16 bits, one pulse if any errored
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			span_ff     <= 4'h0;
			err_seen_ff <= 1'b0;
			cv_left_ff  <= 2'h0;
		end else begin
			if (cv_left_ff != 2'h0) begin
				cv_left_ff <= cv_left_ff - 2'h1;
			end
			if (rx_bit_valid) begin
				span_ff <= span_ff + 4'h1;
				if (span_ff == 4'(`CLM_CV_SPAN - 1)) begin
					err_seen_ff <= 1'b0;
					if (err_seen_ff || rx_code_err) begin
						cv_left_ff <= 2'(`CLM_CV_CYC); // [R4]
					end
				end else if (rx_code_err) begin
					err_seen_ff <= 1'b1;
				end
			end
		end
	end

	wire cv_on   = cv_left_ff != 2'h0;
	wire cv_mode = cmi_mode && (!align_en || !par_mode); // [R3]

	// status pins registered so each comes from a flop
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			frame_ff <= 1'b0;
			lock_ff  <= 1'b0;
			alarm_ff <= 1'b0;
			addr_ff  <= 2'h0;
		end else begin
			frame_ff <= cv_mode ? cv_on : fp_ff; // [R3]
			lock_ff  <= lock_s; // [R5]
			alarm_ff <= lost_s || (sw_mode && ctrl_ff[`CLM_C_COMB] && !lock_s); // [R6] [R7]
			addr_ff  <= sw_mode ? s2_ff[14:13] : 2'h0; // [R8]
		end
	end

	// serial receive outputs, data floated in parallel mode
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rbclk_ff <= 1'b0;
			rbdat_ff <= 1'b0;
			oe_ff    <= 1'b0;
			rbyte_ff <= 8'h00;
		end else begin
			oe_ff    <= !par_mode; // [R10]
			rbclk_ff <= !par_mode && rx_bit_valid; // [R11]
			if (rx_bit_valid) begin
				rbdat_ff <= rx_bit_data; // [R11]
			end
			if (rx_byte_valid) begin
				rbyte_ff <= par_mode ? rx_byte_data : 8'h00;
			end
		end
	end

	assign rx_frame_pulse   = frame_ff;
	assign rx_pll_lock      = lock_ff;
	assign no_signal_alarm  = alarm_ff;
	assign host_addr        = addr_ff;
	assign rx_bit_clock_p   = rbclk_ff;
	assign rx_bit_clock_n   = !rbclk_ff;
	assign rx_serial_data_p = rbdat_ff;
	assign rx_serial_data_n = !rbdat_ff;
	assign rx_serial_oe     = oe_ff;
	assign rx_byte_out      = rbyte_ff;

	default clocking dc @(posedge clk); endclocking
	default disable iff (!arst_n);

	fp_final_a2_a: assert property ( // [R1]
		(rx_byte_valid && frame_act && hit && fp_pos == 4'h0) |=> fp_ff)
		else $error("no frame pulse on final marker byte");
	fp_one_byte_a: assert property ( // [R22]
		(fp_ff && rx_byte_valid && !fire) |=> !fp_ff)
		else $error("frame pulse outlasts one byte");
	fp_steady_a: assert property ( // [R22]
		(fp_ff && !rx_byte_valid) |=> fp_ff)
		else $error("frame pulse dropped mid byte");
	cv_width_a: assert property ( // [R4]
		$rose(cv_on) |-> cv_on [*2] ##1 !cv_on)
		else $error("violation pulse width wrong");
	cv_route_a: assert property ( // [R3]
		cv_mode && $stable(cv_mode) |=> rx_frame_pulse == $past(cv_on))
		else $error("violation not routed to pulse pin");
	lock_follow_a: assert property ( // [R5]
		$rose(pll_locked) ##1 pll_locked [*3] |=> rx_pll_lock)
		else $error("lock output not following PLL");
	alarm_lost_a: assert property ( // [R6]
		signal_lost [*3] |=> no_signal_alarm)
		else $error("signal alarm missing");
	alarm_comb_a: assert property ( // [R7]
		(sw_mode && ctrl_ff[`CLM_C_COMB] && !pll_locked) [*3] |=> no_signal_alarm)
		else $error("lock loss not merged into alarm");
	serial_float_a: assert property ( // [R10]
		par_mode && $past(par_mode) |-> !rx_serial_oe)
		else $error("serial data driven in parallel mode");
	halt_line_a: assert property ( // [R17]
		missing |=> !fiber_out_p && !fiber_out_n && !coax_out_p && !coax_out_n)
		else $error("line not halted on missing clock");
	msb_first_a: assert property ( // [R21]
		(par_mode && byte_fall) |=> bit_stb_ff && bit_val_ff == $past(byte_s[7]))
		else $error("first bit not the most significant");
	loop_nomon_a: assert property ( // [R19]
		rloop |=> !tx_clock_missing)
		else $error("monitor active in remote loop");

	frame_seen_c: cover property (fire ##1 fp_ff);
	cv_seen_c: cover property (cv_mode && $rose(cv_on));
	miss_seen_c: cover property ($rose(missing) ##[1:20] $fell(missing));
	cmi_tx_c: cover property (cmi_mode && bit_stb_ff && bit_val_ff);
endmodule : clm_line_coder

// >>> hdl/clm_map.svh
// offsets, field positions, reset values and timing counts of the line coder
// Notes on behaviour
// R1: pulse on final A2 of A1A1A2A2
// R2: software mode moves pulse to programmed byte
// R3: coax without alignment or serial: pulse shows violations
// R4: one 50 ns pulse per errored 16 bits
// R5: lock output follows receive PLL lock
// R6: alarm high on weak or sparse signal
// R7: software may merge lock loss into alarm
// R8: software mode: address straps form host address
// R9: strap select high means software mode
// R10: parallel mode tristates serial receive data
// R11: serial mode outputs recovered bit clock
// R12: line code from strap or control bit 0
// R13: parallel byte clock times 8 paces bits
// R14: serial mode runs from supplied bit clock
// R15: CMI to coax pair, NRZ to fiber
// R16: zero low-high, one alternates full level
// R17: 200 ns without clock edge halts line
// R18: halt lasts until clock edges return
// R19: remote loop disables monitor; else software only
// R20: host disables monitor when tx clock referenced
// R21: most significant bit sent first
// R22: frame pulse lasts one byte period
// R23: last-one polarity has defined reset level
// R24: crystal-timed counter restarts on clock edges
`ifndef CLM_MAP_SVH
`define CLM_MAP_SVH
`define CLM_ADDR_W      12
`define CLM_CTRL_OFS    12'h000
`define CLM_STAT_OFS    12'h004
`define CLM_CTRL_W      11
`define CLM_CTRL_RST    11'h306
`define CLM_C_LINE      0
`define CLM_C_MON       1
`define CLM_C_ALIGN     2
`define CLM_C_COMB      3
`define CLM_C_POS       4
`define CLM_C_PAR       8
`define CLM_C_XREF      9
`define CLM_C_RLOOP     10
`define CLM_A1          8'hF6
`define CLM_A2          8'h28
`define CLM_CLK_PS      25000
`define CLM_MISS_NS     200
`define CLM_MISS_CYC    ((`CLM_MISS_NS * 1000) / `CLM_CLK_PS)
`define CLM_CV_NS       50
`define CLM_CV_CYC      ((`CLM_CV_NS * 1000) / `CLM_CLK_PS)
`define CLM_CV_SPAN     16
`endif

// >>> hdl/clm_pkg.sv
// types shared by the line coder files
package clm_pkg;
	typedef enum logic [1:0] {
		CLM_D_IDLE = 2'b00,
		CLM_D_A1   = 2'b01,
		CLM_D_A1A1 = 2'b10,
		CLM_D_A2   = 2'b11
	} clm_det_t;
	typedef enum logic {
		CLM_NRZ = 1'b0,
		CLM_CMI = 1'b1
	} clm_line_t;
endpackage : clm_pkg

// >>> testbench/clm_term_model.sv
// overhead terminator model: byte clock and byte data of the system side
`timescale 1ns/1ps
module clm_term_model (
	input  wire logic       run,
	input  wire logic [7:0] next_byte,
	output logic            tx_byte_clock,
	output logic [7:0]      tx_byte_in
);
	// 200 ns byte clock, odd phase so it never lines up with the core clock
	initial begin
		tx_byte_clock = 1'b0;
		tx_byte_in    = 8'h00;
		#37;
		forever begin
			if (run) begin
				tx_byte_clock = 1'b1;
				tx_byte_in    = next_byte;
				#100;
				tx_byte_clock = 1'b0;
				#100;
			end else begin
				#100;
			end
		end
	end
endmodule : clm_term_model

// >>> testbench/cmi_line_coder_clock_monitor_bench.sv
// self-checking bench for the line coder, clock monitor and status pins
`timescale 1ns/1ps
module cmi_line_coder_clock_monitor_bench;
	logic        clk, arst_n, hsel, hwrite, hready, hreadyout, hresp, run;
	logic [11:0] haddr;
	logic [1:0]  htrans, host_addr;
	logic [2:0]  hsize;
	logic [31:0] hwdata, hrdata, rdv;
	logic        strap_select, line_mode_pin, parallel_sel_pin, xtal_ref_pin;
	logic        rx_align_enable_pin, remote_loop_select, chip_addr_bit_one, chip_addr_bit_zero;
	logic [7:0]  tx_byte_in, next_byte, rx_byte_data, rx_byte_out, cap;
	logic        tx_byte_clock, pll_locked, signal_lost, rx_byte_valid, rx_bit_valid;
	logic        rx_bit_data, rx_code_err, coax_out_p, coax_out_n, fiber_out_p, fiber_out_n;
	logic        rx_frame_pulse, rx_pll_lock, no_signal_alarm, rx_bit_clock_p, rx_bit_clock_n;
	logic        rx_serial_data_p, rx_serial_data_n, rx_serial_oe, tx_clock_missing;
	int          miscompares, samples_checked, n, t0, hi;
	logic [7:0]  seq [10] = '{8'hF6, 8'hF6, 8'h28, 8'h28, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h5A};

	assign hready = hreadyout;

	clm_line_coder dut (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .strap_select(strap_select),
		.line_mode_pin(line_mode_pin), .parallel_sel_pin(parallel_sel_pin),
		.xtal_ref_pin(xtal_ref_pin), .rx_align_enable_pin(rx_align_enable_pin),
		.remote_loop_select(remote_loop_select), .chip_addr_bit_one(chip_addr_bit_one),
		.chip_addr_bit_zero(chip_addr_bit_zero), .tx_byte_clock(tx_byte_clock),
		.tx_byte_in(tx_byte_in), .tx_bit_clock_p(tx_byte_clock),
		.tx_serial_data_p(tx_byte_in[7]),
		.pll_locked(pll_locked), .signal_lost(signal_lost), .rx_byte_valid(rx_byte_valid),
		.rx_byte_data(rx_byte_data), .rx_bit_valid(rx_bit_valid), .rx_bit_data(rx_bit_data),
		.rx_code_err(rx_code_err), .coax_out_p(coax_out_p), .coax_out_n(coax_out_n),
		.fiber_out_p(fiber_out_p), .fiber_out_n(fiber_out_n), .rx_frame_pulse(rx_frame_pulse),
		.rx_pll_lock(rx_pll_lock), .no_signal_alarm(no_signal_alarm),
		.rx_bit_clock_p(rx_bit_clock_p), .rx_bit_clock_n(rx_bit_clock_n),
		.rx_serial_data_p(rx_serial_data_p), .rx_serial_data_n(rx_serial_data_n),
		.rx_serial_oe(rx_serial_oe), .rx_byte_out(rx_byte_out), .host_addr(host_addr),
		.tx_clock_missing(tx_clock_missing));

	clm_term_model term (.run(run), .next_byte(next_byte), .tx_byte_clock(tx_byte_clock),
		.tx_byte_in(tx_byte_in));

	// 40 MHz core clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic summarize();
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : summarize

	// single word transfer; waits on hready, never on a fixed count
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		@(posedge clk);
		haddr  <= a;
		hwrite <= wr;
		hsel   <= 1'b1;
		htrans <= 2'b10;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		rdv = hrdata;
	endtask : bus

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		chk("register", e, rdv);
	endtask : rd

	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
	endtask : cyc

	task automatic do_reset();
		arst_n <= 1'b0;
		cyc(5);
		arst_n <= 1'b1;
		cyc(4);
	endtask : do_reset

	function automatic logic probe(input int sel);
		case (sel)
			0: return tx_clock_missing;
			1: return coax_out_n;
			2: return fiber_out_p;
			default: return coax_out_p ~^ coax_out_n;
		endcase
	endfunction : probe

	// ends on the falling edge where the level was found
	task automatic wait_for(input int sel, input logic v);
		n = 0;
		@(negedge clk);
		while (probe(sel) !== v && n < 60) begin
			@(negedge clk);
			n++;
		end
		chk("wait", 32'(v), 32'(probe(sel)));
	endtask : wait_for

	task automatic rx_byte(input logic [7:0] b);
		@(posedge clk);
		rx_byte_valid <= 1'b1;
		rx_byte_data  <= b;
		@(posedge clk);
		rx_byte_valid <= 1'b0;
		cyc(6);
	endtask : rx_byte

	// marker then idle bytes; pulse start in byte periods after final marker byte
	task automatic frame(input int pos);
		t0 = -1;
		hi = 0;
		fork
			foreach (seq[i]) rx_byte(seq[i]);
			for (int c = 0; c < 100; c++) begin
				@(negedge clk);
				if (rx_frame_pulse === 1'b1) begin
					if (t0 < 0) t0 = c;
					hi++;
				end
			end
		join
		chk("fp_pos", pos, (t0 - 25) / 8);
		chk("fp_len", 8, hi);
		chk("rx_byte", 8'h5A, rx_byte_out);
	endtask : frame

	// hang guard, 20000 cycles, well beyond the under one thousand cycles the run needs
	initial begin
		#500us;
		miscompares++;
		summarize();
	end

	initial begin
		{arst_n, hsel, hwrite, htrans, haddr, hwdata, run, next_byte} = '0;
		hsize = 3'h2;
		{strap_select, line_mode_pin, remote_loop_select, chip_addr_bit_one} = '0;
		{chip_addr_bit_zero, pll_locked, signal_lost, rx_byte_valid, rx_byte_data} = '0;
		{rx_bit_valid, rx_bit_data, rx_code_err} = '0;
		{parallel_sel_pin, xtal_ref_pin, rx_align_enable_pin} = 3'b111;
		do_reset();
		run <= 1'b1;
		chk("hresp", 0, hresp);
		rd(12'h000, 32'h0000_0306);
		rd(12'h008, 32'h0000_0000);
		// first one after reset goes out low, then alternates
		line_mode_pin <= 1'b1;
		wait_for(1, 1'b1);
		next_byte <= 8'hC0;
		@(posedge tx_byte_clock);
		@(posedge clk);
		next_byte <= 8'h00;
		wait_for(3, 1'b1);
		for (int i = 0; i < 4; i++) begin
			cap = {cap[5:0], coax_out_p, coax_out_n};
			@(negedge clk);
		end
		chk("cmi", 8'h35, cap);
		chk("fiber_idle", 0, {fiber_out_p, fiber_out_n});
		cyc(2);
		line_mode_pin <= 1'b0;
		cyc(20);
		next_byte <= 8'hB5;
		@(posedge tx_byte_clock);
		@(posedge clk);
		next_byte <= 8'h00;
		wait_for(2, 1'b1);
		for (int i = 0; i < 8; i++) begin
			cap = {cap[6:0], fiber_out_p};
			@(negedge clk);
		end
		chk("nrz", 8'hB5, cap);
		chk("coax_idle", 0, {coax_out_p, coax_out_n});
		run <= 1'b0;
		wait_for(0, 1'b1);
		@(negedge clk);
		chk("halted", 0, {coax_out_p, coax_out_n, fiber_out_p, fiber_out_n});
		cyc(1);
		run <= 1'b1;
		wait_for(0, 1'b0);
		cyc(1);
		remote_loop_select <= 1'b1;
		run <= 1'b0;
		cyc(40);
		chk("loop_mon", 0, tx_clock_missing);
		run <= 1'b1;
		remote_loop_select <= 1'b0;
		pll_locked <= 1'b1;
		signal_lost <= 1'b1;
		cyc(5);
		chk("status_pins", 3'b110, {rx_pll_lock, no_signal_alarm, rx_serial_oe});
		chk("hw_addr", 0, host_addr);
		signal_lost <= 1'b0;
		frame(0);
		// software mode: straps form the host address
		strap_select <= 1'b1;
		chip_addr_bit_one <= 1'b1;
		cyc(5);
		chk("host_addr", 2'b10, host_addr);
		rd(12'h004, 32'h0000_002A);
		bus(1'b1, 12'h000, 32'h0000_030E);
		rd(12'h000, 32'h0000_030E);
		pll_locked <= 1'b0;
		cyc(5);
		chk("merged", 2'b01, {rx_pll_lock, no_signal_alarm});
		pll_locked <= 1'b1;
		bus(1'b1, 12'h008, 32'hFFFF_FFFF);
		rd(12'h000, 32'h0000_030E);
		bus(1'b1, 12'h000, 32'h0000_0307);
		wait_for(1, 1'b1);
		bus(1'b1, 12'h000, 32'h0000_0304);
		run <= 1'b0;
		cyc(40);
		chk("sw_mon_off", 0, tx_clock_missing);
		run <= 1'b1;
		bus(1'b1, 12'h000, 32'h0000_0326);
		frame(2);
		// serial coax, alignment off: violations counted in spans from reset
		{strap_select, parallel_sel_pin, rx_align_enable_pin, xtal_ref_pin} <= 4'b0000;
		line_mode_pin <= 1'b1;
		do_reset();
		// serial coax: one line bit per bit clock rise
		wait_for(1, 1'b1);
		next_byte <= 8'h80;
		repeat (2) @(posedge tx_byte_clock);
		@(posedge clk);
		next_byte <= 8'h00;
		wait_for(3, 1'b1);
		chk("ser_one1", 0, {coax_out_p, coax_out_n});
		repeat (6) @(negedge clk);
		chk("ser_one2", 3, {coax_out_p, coax_out_n});
		hi = 0;
		t0 = 0;
		fork
			for (int i = 0; i < 32; i++) begin
				@(posedge clk);
				rx_bit_valid <= 1'b1;
				rx_bit_data <= i[0];
				rx_code_err <= (i == 3 || i == 5);
				@(posedge clk);
				rx_bit_valid <= 1'b0;
			end
			for (int c = 0; c < 80; c++) begin
				@(negedge clk);
				hi += int'(rx_frame_pulse === 1'b1);
				t0 += int'(rx_bit_clock_p === 1'b1);
			end
		join
		chk("cv_len", 2, hi);
		chk("rx_clk", 32, t0);
		chk("rx_serial", 4'b0110, {rx_bit_clock_p, rx_bit_clock_n,
			rx_serial_data_p, rx_serial_data_n});
		chk("rx_oe", 1, rx_serial_oe);
		summarize();
	end
endmodule : cmi_line_coder_clock_monitor_bench
